/* common/rcc_pkg.sv */
// rcc_pkg: constants and types shared by the command path control block
// assumes a single 40 MHz clock and control words reached only from the command bus
package rcc_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 25000;           // 40 MHz
	localparam int ACT_TIME_NS   = 1000;            // activation_time, plain default
	localparam int ACT_CYC       = (ACT_TIME_NS * 1000) / CLK_PERIOD_PS; // longest: round down
	localparam int ACT_W         = 8;
	localparam logic [ACT_W-1:0] ACT_CNT = ACT_W'(ACT_CYC);
	localparam logic [1:0] MRS_GAP = 2'h3;          // clocks that keep inversion off
	localparam logic [1:0] T3_HOLD = 2'h2;          // extra clocks a 3T value stands

	// ****************************************
	// control words
	// ****************************************
	localparam int CW_NUM = 16;
	localparam int CW_W   = 4;
	localparam logic [3:0] CW_RST  = 4'h0;          // words 0..5, 8..15
	localparam logic [3:0] CW6_RST = 4'h0;          // arbitrary vendor default
	localparam logic [3:0] CW7_RST = 4'h0;          // arbitrary vendor default
	localparam logic [3:0] CW_GLOBAL = 4'h0;
	localparam logic [3:0] CW_TIMING = 4'h2;        // timing_word
	localparam logic [3:0] CW_POWER  = 4'h9;        // power_saving_word
	localparam int GLB_INV_OFF_BIT = 0;             // 1: output inversion disabled
	localparam int TIM_3T_BIT      = 0;             // 1: 3T timing
	localparam int PWR_TERM_ON_BIT = 0;             // 1: keep termination in power down
	localparam int PWR_SAVE_BIT    = 3;             // 1: clock-enable power down allowed

	// ****************************************
	// pins
	// ****************************************
	localparam logic [15:0] INV_ADDR_MASK = 16'hebf8; // addr 3-9, 11, 13-15
	localparam logic [2:0]  INV_BANK_MASK = 3'h7;
	localparam logic [3:0]  CS_IDLE       = 4'hf;
	localparam logic [3:0]  CS_QUAD_ALL   = 4'h0;
	localparam logic [3:0]  CS_QUAD_HI    = 4'h3;     // selects 3 and 2 low
	localparam logic [3:0]  CS_QUAD_LO    = 4'hc;     // selects 1 and 0 low

	typedef enum logic [3:0] {
		RCC_RUN      = 4'b0001,
		RCC_CKE_PD   = 4'b0010,
		RCC_CLK_STOP = 4'b0100,
		RCC_WAKE     = 4'b1000
	} rcc_state_t;

endpackage

/* rtl/rcc_ctrl_words.sv */
// rcc_ctrl_words: sixteen four-bit control words
// assumes the caller qualifies writes; contents survive anything but reset
`timescale 1ns/1ps

module rcc_ctrl_words (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// write port
	input  wire logic        wr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [3:0]  data_i,
	// all words, word n at bits 4n+3..4n
	output logic      [63:0] words_o
);

	logic [3:0] mem_q [rcc_pkg::CW_NUM];

	// ****************************************
	// storage
	// ****************************************
	// reset restores defaults, reserved words store like any other
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < rcc_pkg::CW_NUM; i++) begin
				mem_q[i] <= (i == 6) ? rcc_pkg::CW6_RST :
				            (i == 7) ? rcc_pkg::CW7_RST : rcc_pkg::CW_RST;
			end
		end else if (wr_i) begin
			mem_q[sel_i] <= data_i;
		end
	end

	// flatten for the reader
	always_comb begin
		for (int i = 0; i < rcc_pkg::CW_NUM; i++) begin
			words_o[i*rcc_pkg::CW_W +: rcc_pkg::CW_W] = mem_q[i];
		end
	end

endmodule

/* rtl/rcc_cmd_ctrl.sv */
// rcc_cmd_ctrl: command path control of a registering clock driver
// assumes host pins are synchronous to clk_i and clk_stopped_i reports the
// input clock pair held low by an outside detector
`timescale 1ns/1ps

module rcc_cmd_ctrl (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// host command bus
	input  wire logic [3:0]  host_chip_sel_in_b_i,
	input  wire logic [1:0]  host_clk_en_in_i,
	input  wire logic [1:0]  host_term_in_i,
	input  wire logic        host_row_strobe_in_b_i,
	input  wire logic        host_col_strobe_in_b_i,
	input  wire logic        host_write_en_in_b_i,
	input  wire logic [15:0] host_addr_in_i,
	input  wire logic [2:0]  host_bank_in_i,
	input  wire logic        host_parity_in_i,
	// configuration and clock detector
	input  wire logic        quad_rank_mode_i,
	input  wire logic        clk_stopped_i,
	// rank side, A outputs
	output logic      [3:0]  rank_chip_sel_out_b_o,
	output logic      [1:0]  rank_clk_en_out_o,
	output logic      [1:0]  rank_term_out_o,
	output logic             a_side_row_strobe_b_o,
	output logic             a_side_col_strobe_b_o,
	output logic             a_side_write_en_b_o,
	output logic      [15:0] a_side_addr_o,
	output logic      [2:0]  a_side_bank_o,
	// rank side, B outputs
	output logic      [15:0] b_side_addr_out_o,
	output logic      [2:0]  b_side_bank_out_o,
	// open-drain error pin
	output logic             parity_error_out_o,
	output logic             parity_error_oe_o,
	// status
	output logic             input_rcv_en_o,
	output logic             input_term_en_o,
	output logic             inversion_en_o,
	output logic             timing_3t_o
);

	// ****************************************
	// helpers
	// ****************************************
	// number of active (low) selects
	function automatic logic [2:0] low_count(input logic [3:0] cs);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 4; i++) begin
			n = n + {2'h0, ~cs[i]};
		end
		return n;
	endfunction

	// ****************************************
	// declarations
	// ****************************************
	rcc_pkg::rcc_state_t      state_q, state_d;
	logic [rcc_pkg::ACT_W-1:0] act_q, act_d;
	logic [1:0]  mrs_cnt_q, mrs_cnt_d;
	logic [1:0]  hold_q, hold_d;
	logic        mrs_pend_q;
	logic [3:0]  mrs_cs_q;
	logic [1:0]  cke_prev_q;
	logic [63:0] words;
	logic [3:0]  cs_eff;
	logic        cw_dual, cw_quad, cw_hit, cw_ok, cw_wr;
	logic        is_mrs, par_bad, live, cke_any, t3, inv_d;
	logic        pwr_save, term_keep, pd_entry, cmd_take, keep_cmd;
	logic [3:0]  cs_d;
	logic [1:0]  cke_d, term_d;
	logic [15:0] addr_d;
	logic [2:0]  bank_d;
	logic        ras_d, cas_d, we_d;

	// ****************************************
	// control words
	// ****************************************
	rcc_ctrl_words u_words (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.wr_i    (cw_wr),
		.sel_i   ({host_bank_in_i[2], host_addr_in_i[2:0]}),
		.data_i  ({host_bank_in_i[1:0], host_addr_in_i[4:3]}),
		.words_o (words)
	);

	// ****************************************
	// decode
	// ****************************************
	// selects 3 and 2 do not exist in dual-rank mode
	assign cs_eff   = quad_rank_mode_i ? host_chip_sel_in_b_i
	                                   : {2'b11, host_chip_sel_in_b_i[1:0]};
	assign cw_dual  = (host_chip_sel_in_b_i[1:0] == 2'b00);
	assign cw_quad  = (host_chip_sel_in_b_i == rcc_pkg::CS_QUAD_ALL) ||
	                  (host_chip_sel_in_b_i == rcc_pkg::CS_QUAD_HI) ||
	                  (host_chip_sel_in_b_i == rcc_pkg::CS_QUAD_LO);
	assign cw_hit   = live && (quad_rank_mode_i ? cw_quad : cw_dual);
	assign cke_any  = |host_clk_en_in_i;
	// strobes and termination play no part in qualifying an access
	assign cw_ok    = cw_hit && cke_any && (host_addr_in_i[15:5] == 11'h000);
	assign par_bad  = host_parity_in_i != ^{host_addr_in_i, host_bank_in_i,
	                  host_row_strobe_in_b_i, host_col_strobe_in_b_i, host_write_en_in_b_i};
	assign cw_wr    = cw_ok && !par_bad;
	// mode set: all strobes low with exactly one select low
	assign is_mrs   = live && !cw_hit && !host_row_strobe_in_b_i &&
	                  !host_col_strobe_in_b_i && !host_write_en_in_b_i &&
	                  (low_count(cs_eff) == 3'h1);
	assign cmd_take = live && !cw_hit && (cs_eff != rcc_pkg::CS_IDLE);

	// configuration bits from the words
	assign t3       = words[rcc_pkg::CW_TIMING*rcc_pkg::CW_W + rcc_pkg::TIM_3T_BIT];
	assign pwr_save = words[rcc_pkg::CW_POWER*rcc_pkg::CW_W + rcc_pkg::PWR_SAVE_BIT];
	assign term_keep = words[rcc_pkg::CW_POWER*rcc_pkg::CW_W + rcc_pkg::PWR_TERM_ON_BIT];
	// inversion off while a mode set is in flight or the global word says so
	assign inv_d    = !words[rcc_pkg::CW_GLOBAL*rcc_pkg::CW_W + rcc_pkg::GLB_INV_OFF_BIT]
	                  && !is_mrs && (mrs_cnt_q == 2'h0);

	// both enables low now, at least one was high before
	assign pd_entry = pwr_save && !cke_any && (cke_prev_q != 2'b00);
	assign live     = (state_q == rcc_pkg::RCC_RUN);

	// ****************************************
	// power state sequencing
	// ****************************************
	always_comb begin
		state_d = state_q;
		act_d   = act_q;
		unique case (state_q)
			rcc_pkg::RCC_RUN: begin
				if (clk_stopped_i) begin
					state_d = rcc_pkg::RCC_CLK_STOP;
				end else if (pd_entry) begin
					state_d = rcc_pkg::RCC_CKE_PD;
				end
			end
			rcc_pkg::RCC_CKE_PD: begin
				if (clk_stopped_i) begin
					state_d = rcc_pkg::RCC_CLK_STOP;
				end else if (cke_any) begin
					state_d = rcc_pkg::RCC_RUN;
				end
			end
			rcc_pkg::RCC_CLK_STOP: begin
				if (!clk_stopped_i) begin
					state_d = rcc_pkg::RCC_WAKE;
					act_d   = rcc_pkg::ACT_CNT;
				end
			end
			rcc_pkg::RCC_WAKE: begin
				if (clk_stopped_i) begin
					state_d = rcc_pkg::RCC_CLK_STOP;
				end else if (act_q <= 8'h01) begin
					state_d = rcc_pkg::RCC_RUN;
				end else begin
					act_d = act_q - 8'h01;
				end
			end
		endcase
	end

	// ****************************************
	// command path next values
	// ****************************************
	// a value stands while 3T hold runs, during control access or power down
	assign keep_cmd = !live || cw_hit || (hold_q != 2'h0);
	assign addr_d   = keep_cmd ? a_side_addr_o : host_addr_in_i;
	assign bank_d   = keep_cmd ? a_side_bank_o : host_bank_in_i;
	assign ras_d    = keep_cmd ? a_side_row_strobe_b_o : host_row_strobe_in_b_i;
	assign cas_d    = keep_cmd ? a_side_col_strobe_b_o : host_col_strobe_in_b_i;
	assign we_d     = keep_cmd ? a_side_write_en_b_o : host_write_en_in_b_i;
	assign hold_d   = (hold_q != 2'h0) ? hold_q - 2'h1 :
	                  (cmd_take && t3) ? rcc_pkg::T3_HOLD : 2'h0;
	assign mrs_cnt_d = is_mrs ? rcc_pkg::MRS_GAP :
	                   (mrs_cnt_q != 2'h0) ? mrs_cnt_q - 2'h1 : 2'h0;

	// selects skip the 3T hold; a mode set goes out one clock late
	assign cs_d     = mrs_pend_q ? mrs_cs_q :
	                  (!live || cw_hit || is_mrs) ? rcc_pkg::CS_IDLE : cs_eff;
	// clock-enable outputs low while clocks are stopped, held on control access
	assign cke_d    = (state_q == rcc_pkg::RCC_CLK_STOP) ? 2'b00 :
	                  cw_hit ? rank_clk_en_out_o : host_clk_en_in_i;
	assign term_d   = (state_q == rcc_pkg::RCC_CLK_STOP ||
	                   state_q == rcc_pkg::RCC_WAKE) ? 2'b00 :
	                  cw_hit ? rank_term_out_o : host_term_in_i;

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q    <= rcc_pkg::RCC_RUN;
			act_q      <= '0;
			mrs_cnt_q  <= 2'h0;
			hold_q     <= 2'h0;
			mrs_pend_q <= 1'b0;
			mrs_cs_q   <= rcc_pkg::CS_IDLE;
			cke_prev_q <= 2'b00;
		end else begin
			state_q    <= state_d;
			act_q      <= act_d;
			mrs_cnt_q  <= mrs_cnt_d;
			hold_q     <= hold_d;
			mrs_pend_q <= is_mrs;
			mrs_cs_q   <= cs_eff;
			cke_prev_q <= host_clk_en_in_i;
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	// B side carries the complement of the listed A bits while inversion is on
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rank_chip_sel_out_b_o <= rcc_pkg::CS_IDLE;
			rank_clk_en_out_o     <= 2'b00;
			rank_term_out_o       <= 2'b00;
			a_side_row_strobe_b_o <= 1'b1;
			a_side_col_strobe_b_o <= 1'b1;
			a_side_write_en_b_o   <= 1'b1;
			a_side_addr_o         <= 16'h0000;
			a_side_bank_o         <= 3'h0;
			b_side_addr_out_o     <= rcc_pkg::INV_ADDR_MASK;
			b_side_bank_out_o     <= rcc_pkg::INV_BANK_MASK;
			inversion_en_o        <= 1'b1;
		end else begin
			rank_chip_sel_out_b_o <= cs_d;
			rank_clk_en_out_o     <= cke_d;
			rank_term_out_o       <= term_d;
			a_side_row_strobe_b_o <= ras_d;
			a_side_col_strobe_b_o <= cas_d;
			a_side_write_en_b_o   <= we_d;
			a_side_addr_o         <= addr_d;
			a_side_bank_o         <= bank_d;
			b_side_addr_out_o     <= addr_d ^ (inv_d ? rcc_pkg::INV_ADDR_MASK : 16'h0000);
			b_side_bank_out_o     <= bank_d ^ (inv_d ? rcc_pkg::INV_BANK_MASK : 3'h0);
			inversion_en_o        <= inv_d;
		end
	end

	// ****************************************
	// error pin and status
	// ****************************************
	// error pulls the pin low for one clock; receivers follow the power state
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			parity_error_out_o <= 1'b0;
			parity_error_oe_o  <= 1'b0;
			input_rcv_en_o     <= 1'b1;
			input_term_en_o    <= 1'b1;
			timing_3t_o        <= 1'b0;
		end else begin
			parity_error_out_o <= 1'b0;
			parity_error_oe_o  <= cw_ok && par_bad;
			input_rcv_en_o     <= (state_d != rcc_pkg::RCC_CLK_STOP);
			input_term_en_o    <= (state_d == rcc_pkg::RCC_RUN) ||
			                      (state_d == rcc_pkg::RCC_WAKE) ||
			                      (state_d == rcc_pkg::RCC_CKE_PD && term_keep);
			timing_3t_o        <= t3;
		end
	end

endmodule

/* tb/rcc_cmd_ctrl_props.sv */
// rcc_cmd_ctrl_props: port checker for the command path control block
// assumes binding to rcc_cmd_ctrl and a host that keeps mode sets apart
`timescale 1ns/1ps

module rcc_cmd_ctrl_props (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// host side
	input wire logic [3:0]  host_chip_sel_in_b_i,
	input wire logic [1:0]  host_clk_en_in_i,
	input wire logic        host_row_strobe_in_b_i,
	input wire logic        host_col_strobe_in_b_i,
	input wire logic        host_write_en_in_b_i,
	input wire logic [15:0] host_addr_in_i,
	input wire logic [2:0]  host_bank_in_i,
	input wire logic        host_parity_in_i,
	input wire logic        quad_rank_mode_i,
	input wire logic        clk_stopped_i,
	// rank side and status
	input wire logic [3:0]  rank_chip_sel_out_b_o,
	input wire logic [1:0]  rank_clk_en_out_o,
	input wire logic [15:0] a_side_addr_o,
	input wire logic [2:0]  a_side_bank_o,
	input wire logic [15:0] b_side_addr_out_o,
	input wire logic [2:0]  b_side_bank_out_o,
	input wire logic        parity_error_oe_o,
	input wire logic        input_rcv_en_o,
	input wire logic        input_term_en_o,
	input wire logic        inversion_en_o,
	input wire logic        timing_3t_o
);
	// ****************************************
	// host pin decode
	// ****************************************
	logic [5:0] quiet_q;
	logic       en_q;
	wire logic [3:0] cs = host_chip_sel_in_b_i;
	wire logic [2:0] c3 = {host_row_strobe_in_b_i, host_col_strobe_in_b_i, host_write_en_in_b_i};
	// run: long after reset or wake, clock enables high now and before
	wire logic run = (quiet_q > 6'h2c) && en_q && (|host_clk_en_in_i);
	wire logic mode_register_set_cmd = !quad_rank_mode_i && (cs == 4'he || cs == 4'hd) && (c3 == 3'h0);
	wire logic low = !(&cs[1:0]) || (quad_rank_mode_i && !(&cs[3:2]));
	// select pattern of an access; the design holds on it whatever the address
	wire logic acc = quad_rank_mode_i ? (cs == 4'h0 || cs == 4'h3 || cs == 4'hc)
		: (cs[1:0] == 2'h0);
	wire logic cw = acc && (|host_clk_en_in_i) && (host_addr_in_i[15:5] == 11'h0);
	wire logic bad = host_parity_in_i != ^{host_addr_in_i, host_bank_in_i, c3};

	// cycles since reset or clock stop, saturating
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || clk_stopped_i) begin
			quiet_q <= 6'h0;
		end else if (quiet_q != 6'h3f) begin
			quiet_q <= quiet_q + 6'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		en_q <= |host_clk_en_in_i;
	end

	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_inv_pair;
		b_side_addr_out_o == (a_side_addr_o ^ (inversion_en_o ? rcc_pkg::INV_ADDR_MASK : 16'h0))
		&& b_side_bank_out_o == (a_side_bank_o ^ (inversion_en_o ? rcc_pkg::INV_BANK_MASK : 3'h0));
	endproperty
	a_inv_pair: assert property (p_inv_pair) else $error("b side not matching a side");
	property p_mrs_seq;
		run && mode_register_set_cmd |=> (rank_chip_sel_out_b_o == rcc_pkg::CS_IDLE && !inversion_en_o)
		##1 rank_chip_sel_out_b_o == $past(host_chip_sel_in_b_i, 2);
	endproperty
	a_mrs_seq: assert property (p_mrs_seq) else $error("mode set not delayed");
	property p_inv_back;
		run && mode_register_set_cmd ##1 !mode_register_set_cmd [*3] |=> !inversion_en_o ##1 ($past(mode_register_set_cmd) || inversion_en_o);
	endproperty
	a_inv_back: assert property (p_inv_back) else $error("inversion not restored");
	property p_cw_hold;
		run && cw |=> rank_chip_sel_out_b_o == rcc_pkg::CS_IDLE && $stable(a_side_addr_o)
		&& $stable(rank_clk_en_out_o);
	endproperty
	a_cw_hold: assert property (p_cw_hold) else $error("outputs moved on access");
	property p_parity;
		run && cw |=> parity_error_oe_o == $past(bad);
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag wrong");
	property p_hold_3t;
		run && timing_3t_o && low && !acc && !mode_register_set_cmd |=> ##1 $stable(a_side_addr_o) [*2];
	endproperty
	a_hold_3t: assert property (p_hold_3t) else $error("3t value not held");
	property p_follow;
		run && !timing_3t_o && !acc |=> a_side_addr_o == $past(host_addr_in_i)
		&& a_side_bank_o == $past(host_bank_in_i);
	endproperty
	a_follow: assert property (p_follow) else $error("outputs not following");
	property p_stop;
		clk_stopped_i [*2] |=> !input_rcv_en_o && !input_term_en_o
		&& rank_clk_en_out_o == 2'h0 && rank_chip_sel_out_b_o == rcc_pkg::CS_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("inputs live while stopped");

	c_mrs: cover property (run && mode_register_set_cmd);
	c_bad: cover property (run && cw && bad);
	c_stop: cover property (clk_stopped_i [*2]);
endmodule

bind rcc_cmd_ctrl rcc_cmd_ctrl_props i_rcc_cmd_ctrl_props (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .host_chip_sel_in_b_i(host_chip_sel_in_b_i),
	.host_clk_en_in_i(host_clk_en_in_i), .host_row_strobe_in_b_i(host_row_strobe_in_b_i),
	.host_col_strobe_in_b_i(host_col_strobe_in_b_i), .host_write_en_in_b_i(host_write_en_in_b_i),
	.host_addr_in_i(host_addr_in_i), .host_bank_in_i(host_bank_in_i),
	.host_parity_in_i(host_parity_in_i), .quad_rank_mode_i(quad_rank_mode_i),
	.clk_stopped_i(clk_stopped_i), .rank_chip_sel_out_b_o(rank_chip_sel_out_b_o),
	.rank_clk_en_out_o(rank_clk_en_out_o), .a_side_addr_o(a_side_addr_o),
	.a_side_bank_o(a_side_bank_o), .b_side_addr_out_o(b_side_addr_out_o),
	.b_side_bank_out_o(b_side_bank_out_o), .parity_error_oe_o(parity_error_oe_o),
	.input_rcv_en_o(input_rcv_en_o), .input_term_en_o(input_term_en_o),
	.inversion_en_o(inversion_en_o), .timing_3t_o(timing_3t_o)
);

/* tb/rcc_host.sv */
// rcc_host: host memory controller model driving the command bus
// assumes a free clock; stopped_o stands for the input clock pair held low
`timescale 1ns/1ps

module rcc_host (
	// clock
	input  wire logic        clk_i,
	// command bus
	output logic      [3:0]  cs_b_o,
	output logic      [2:0]  cmd_b_o,
	output logic      [15:0] addr_o,
	output logic      [2:0]  bank_o,
	output logic             par_o,
	output logic      [1:0]  clk_en_o,
	output logic      [1:0]  term_o,
	// clock pair held low
	output logic             stopped_o
);
	// idle bus at time zero, parity even
	initial begin
		{cs_b_o, cmd_b_o, addr_o, bank_o, term_o} = {4'hf, 3'h7, 16'h0, 3'h0, 2'h0};
		par_o = 1'h1;
		clk_en_o = 2'h3;
		stopped_o = 1'h0;
	end

	// one request for one clock, then selects released and lines scrambled
	task automatic drive(input logic [3:0] cs, input logic [2:0] cmd, input logic [15:0] a,
		input logic [2:0] b, input logic flip);
		@(posedge clk_i);
		{cs_b_o, cmd_b_o, addr_o, bank_o, term_o} <= {cs, cmd, a, b, a[1:0]};
		par_o <= ^{a, b, cmd} ^ flip;
		@(posedge clk_i);
		{cs_b_o, cmd_b_o, addr_o, bank_o} <= {4'hf, 3'h7, ~a, ~b};
		par_o <= ^{~a, ~b, 3'h7};
	endtask

	// clock enables low for a while before the clock stops
	task automatic clk_en_off;
		@(posedge clk_i);
		clk_en_o <= 2'h0;
		repeat (4) @(posedge clk_i);
	endtask

	// clock pair low and enables steady; released address keeps changing
	task automatic stop_clock;
		@(posedge clk_i);
		stopped_o <= 1'h1;
		repeat (4) begin
			@(posedge clk_i);
			addr_o <= ~addr_o;
		end
	endtask

	// selects high and clock back together, enables low through the settle time, then enables high
	task automatic wake;
		@(posedge clk_i);
		cs_b_o <= 4'hf;
		stopped_o <= 1'h0;
		repeat (rcc_pkg::ACT_CYC + 4) @(posedge clk_i);
		clk_en_o <= 2'h3;
		@(posedge clk_i);
	endtask
endmodule

/* tb/test_rcc_cmd_ctrl.sv */
// test_rcc_cmd_ctrl: self-checking bench for the command path control block
// assumes rcc_host as the host and the bound port checker
`timescale 1ns/1ps

module test_rcc_cmd_ctrl;
	typedef struct packed {
		logic        quad;
		logic [3:0]  cs;
		logic [15:0] addr;
		logic [2:0]  bank;
		logic [3:0]  sel;
	} rcc_row_t;

	logic        clk;
	logic        rst_b;
	logic        quad;
	logic [3:0]  cs_b;
	logic [2:0]  cmd_b;
	logic [15:0] addr;
	logic [2:0]  bank;
	logic        par;
	logic [1:0]  clk_en;
	logic [1:0]  term;
	logic        stopped;
	logic [3:0]  sel;
	logic [15:0] a_addr;
	logic [2:0]  a_bank;
	logic [2:0]  q_cmd;
	logic [1:0]  q_term;
	logic [15:0] b_addr;
	logic [2:0]  b_bank;
	logic        oe;
	logic        rcv;
	logic        term_en;
	logic        inv;
	logic        t3;
	int          n_mismatch = 0;
	int          compares = 0;
	int          cycles = 0;
	// commands: one or two selects low, never three in quad mode
	rcc_row_t    rows [5] = '{'{1'h0, 4'he, 16'h1234, 3'h5, 4'he},
		'{1'h0, 4'h2, 16'hffff, 3'h0, 4'he}, '{1'h1, 4'h7, 16'h0001, 3'h7, 4'h7},
		'{1'h1, 4'hb, 16'h8000, 3'h2, 4'hb}, '{1'h1, 4'h9, 16'h0020, 3'h1, 4'h9}};
	// accesses {selects, word, data, inversion after}
	logic [12:0] cwt [3] = '{{4'h3, 4'h0, 4'h1, 1'h0}, {4'h0, 4'h0, 4'h0, 1'h1},
		{4'hc, 4'hc, 4'hf, 1'h1}};

	rcc_host i_rcc_host (.clk_i(clk), .cs_b_o(cs_b), .cmd_b_o(cmd_b), .addr_o(addr),
		.bank_o(bank), .par_o(par), .clk_en_o(clk_en), .term_o(term), .stopped_o(stopped));
	rcc_cmd_ctrl i_rcc_cmd_ctrl (.clk_i(clk), .rst_b_i(rst_b), .host_chip_sel_in_b_i(cs_b),
		.host_clk_en_in_i(clk_en), .host_term_in_i(term), .host_row_strobe_in_b_i(cmd_b[2]),
		.host_col_strobe_in_b_i(cmd_b[1]), .host_write_en_in_b_i(cmd_b[0]),
		.host_addr_in_i(addr), .host_bank_in_i(bank), .host_parity_in_i(par),
		.quad_rank_mode_i(quad), .clk_stopped_i(stopped), .rank_chip_sel_out_b_o(sel),
		.rank_clk_en_out_o(), .rank_term_out_o(q_term),
		.a_side_row_strobe_b_o(q_cmd[2]), .a_side_col_strobe_b_o(q_cmd[1]),
		.a_side_write_en_b_o(q_cmd[0]), .a_side_addr_o(a_addr),
		.a_side_bank_o(a_bank), .b_side_addr_out_o(b_addr), .b_side_bank_out_o(b_bank),
		.parity_error_out_o(), .parity_error_oe_o(oe), .input_rcv_en_o(rcv),
		.input_term_en_o(term_en), .inversion_en_o(inv), .timing_3t_o(t3));

	// ****************************************
	// clock, timeout and helpers
	// ****************************************
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// word select and data packed onto address and bank, strobes all low
	task automatic cw(input logic [3:0] cs, input logic [3:0] w, input logic [3:0] d,
		input logic flip);
		i_rcc_host.drive(cs, 3'h0, {11'h0, d[1:0], w[2:0]}, {w[3], d[3:2]}, flip);
	endtask
	task automatic end_of_test;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		rst_b = 1'h0;
		quad = 1'h0;
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		#1;
		chk({sel, b_addr, inv, t3}, {rcc_pkg::CS_IDLE, rcc_pkg::INV_ADDR_MASK, 2'h2});
		repeat (48) @(posedge clk);
		foreach (rows[i]) begin
			@(posedge clk);
			quad <= rows[i].quad;
			i_rcc_host.drive(rows[i].cs, 3'h3, rows[i].addr, rows[i].bank, 1'h0);
			#1;
			chk({sel, a_addr, b_addr}, {rows[i].sel, rows[i].addr,
				rows[i].addr ^ rcc_pkg::INV_ADDR_MASK});
			chk({b_bank, a_bank, q_cmd, q_term}, {rows[i].bank ^ rcc_pkg::INV_BANK_MASK,
				rows[i].bank, 3'h3, rows[i].addr[1:0]});
		end
		@(posedge clk);
		quad <= 1'h0;
		i_rcc_host.drive(4'hd, 3'h0, 16'h0431, 3'h2, 1'h0);
		#1;
		chk({sel, inv, a_addr, b_addr, q_cmd}, {rcc_pkg::CS_IDLE, 1'h0, 16'h0431,
			16'h0431, 3'h0});
		@(posedge clk);
		#1;
		chk(sel, 4'hd);
		repeat (2) @(posedge clk);
		#1;
		chk(inv, 1'h0);
		@(posedge clk);
		#1;
		chk(inv, 1'h1);
		i_rcc_host.drive(4'he, 3'h3, 16'h5a5a, 3'h1, 1'h0);
		cw(4'hc, 4'h0, 4'h1, 1'h1);
		#1;
		chk({sel, a_addr, oe, q_cmd, q_term}, {rcc_pkg::CS_IDLE, 16'ha5a5, 1'h1,
			3'h7, 2'h2});
		@(posedge clk);
		#1;
		chk({oe, inv}, 2'h1);
		foreach (cwt[i]) begin
			@(posedge clk);
			quad <= 1'h1;
			cw(cwt[i][12:9], cwt[i][8:5], cwt[i][4:1], 1'h0);
			@(posedge clk);
			#1;
			chk(inv, cwt[i][0]);
		end
		cw(4'h3, 4'h2, 4'h1, 1'h0);
		// timing word changed: selects stay high while the clock timing settles
		repeat (rcc_pkg::ACT_CYC) @(posedge clk);
		i_rcc_host.drive(4'h7, 3'h3, 16'h1111, 3'h0, 1'h0);
		#1;
		chk({t3, a_addr}, {1'h1, 16'h1111});
		repeat (2) @(posedge clk);
		#1;
		chk({sel, a_addr}, {rcc_pkg::CS_IDLE, 16'h1111});
		cw(4'h3, 4'h9, 4'h8, 1'h0);
		i_rcc_host.clk_en_off();
		#1;
		chk(term_en, 1'h0);
		i_rcc_host.stop_clock();
		#1;
		chk({rcv, term_en}, 2'h0);
		i_rcc_host.wake();
		i_rcc_host.drive(4'hb, 3'h3, 16'h2222, 3'h0, 1'h0);
		#1;
		chk({t3, a_addr}, {1'h1, 16'h2222});
		@(posedge clk);
		rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		#1;
		chk({t3, inv, sel}, {2'h1, rcc_pkg::CS_IDLE});
		end_of_test();
	end
endmodule
